// ===== logic/prog_macrocell.sv
// Ten-macrocell programmable output block with preload and security
`timescale 1ns/1ns
`include "pmc_cfg.svh"

module prog_macrocell (
    input wire logic core_clk,             // 125 MHz core clock
    input wire logic rst,                  // Synchronous reset, active high
    input wire logic hsel,                 // AHB slave select
    input wire logic [31:0] haddr,         // AHB address
    input wire logic [1:0] htrans,         // AHB transfer type
    input wire logic hwrite,               // AHB write flag
    input wire logic [2:0] hsize,          // AHB size, word only
    input wire logic [31:0] hwdata,        // AHB write data
    input wire logic hready,               // AHB bus ready
    output logic hreadyout,                // AHB slave ready
    output logic [31:0] hrdata,            // AHB read data
    output logic hresp,                    // AHB response
    input wire logic [5:0] dedIn,          // Dedicated array input pins
    input wire logic pldClk,               // Device clock pin
    input wire logic [9:0] ioIn,           // I/O pin levels
    output logic [9:0] ioOut,              // I/O pin drive values
    output logic [9:0] ioOe,               // I/O pin drive enables
    input wire logic preloadStrobe,        // Preload strobe, high when elevated
    input wire logic preloadEnable         // Preload qualifier pin
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // One product term: a set cell disconnects that literal
    function automatic logic termEval(input logic [31:0] w, input logic [15:0] a);
        logic t;
        t = 1'b1;
        for (int k = 0; k < `PMC_ARR; k++)
        begin
            t &= (w[2*k] | a[k]) & (w[2*k+1] | ~a[k]);
        end
        return t;
    endfunction : termEval

    // Sum width of a macrocell, widest in the middle
    function automatic int widthOf(input int i);
        int m;
        m = (i < 5) ? i : 9 - i;
        return `PMC_MIN_SUM + 2 * m;
    endfunction : widthOf

    // First term of a macrocell: its enable term, then its sum terms
    function automatic int baseOf(input int i);
        int b;
        b = 0;
        for (int j = 0; j < i; j++)
        begin
            b += 1 + widthOf(j);
        end
        return b;
    endfunction : baseOf

    ////////////////////////////////////////////////////////////////////////////
    // State

    pmc_pkg::state_t s_q;         // Registered state
    pmc_pkg::state_t s_d;         // Next state
    logic [15:0] arr;             // Array input signals
    logic [9:0] dVal;             // Polarised sum per macrocell
    logic [9:0] oeVal;            // Enable term per macrocell
    logic [9:0] regMask;          // Macrocells in registered mode
    logic setT;                   // Global set term
    logic rstT;                   // Global reset term
    logic clkEdge;                // Device clock rising edge
    logic preload;                // Qualified preload strobe edge
    logic accept;                 // Bus address phase taken
    logic [31:0] rdWord;          // Word for the pending read

    ////////////////////////////////////////////////////////////////////////////
    // Array and macrocell logic

    // Feedback, term sums, polarity and global terms
    always_comb
    begin
        logic sum;
        sum = 1'b0;
        for (int i = 0; i < `PMC_CELLS; i++)
        begin
            regMask[i] = s_q.cfg[2*i];
            // Combinatorial cells feed back the pin so it serves as an input
            arr[`PMC_DED+i] = regMask[i] ? s_q.regQ[i] : s_q.pinS2[i];
        end
        arr[`PMC_DED-1:0] = s_q.dedS2;
        for (int i = 0; i < `PMC_CELLS; i++)
        begin
            sum = 1'b0;
            // Only this cell's own share of sum terms is ORed
            for (int k = 0; k < `PMC_WIDE_SUM; k++)
            begin
                if (k < widthOf(i))
                begin
                    sum |= termEval(s_q.term[baseOf(i) + 1 + k], arr);
                end
            end
            // Second cell of the pair selects noninverting
            dVal[i] = sum ^ ~s_q.cfg[2*i+1];
            oeVal[i] = termEval(s_q.term[baseOf(i)], arr);
        end
        setT = termEval(s_q.term[`PMC_SET_IDX], arr);
        rstT = termEval(s_q.term[`PMC_RST_IDX], arr);
        clkEdge = s_q.clkS[1] & ~s_q.clkS[2];
        preload = s_q.strbS[1] & ~s_q.strbS[2] & s_q.enS[1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read mux

    // Array and configuration read as zero once secured
    always_comb
    begin
        rdWord = 32'h0000_0000;
        if (s_q.idx < `PMC_CFG_IDX)
        begin
            rdWord = s_q.secure ? 32'h0000_0000 : s_q.term[s_q.idx];
        end
        else if (s_q.idx == `PMC_CFG_IDX)
        begin
            rdWord = s_q.secure ? 32'h0000_0000 : {12'h000, s_q.cfg};
        end
        else if (s_q.idx == `PMC_CTRL_IDX)
        begin
            rdWord = {31'h0000_0000, s_q.secure};
        end
        else if (s_q.idx == `PMC_STAT_IDX)
        begin
            rdWord = {22'h00_0000, s_q.regQ};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Synchronisers, output registers, pins and bus slave
    always_comb
    begin
        s_d = s_q;
        accept = hsel & htrans[1] & hready & (s_q.bus == pmc_pkg::BUS_IDLE);
        // Two-stage synchronisers; history stage used for edges only
        s_d.pinS1 = ioIn;
        s_d.pinS2 = s_q.pinS1;
        s_d.dedS1 = dedIn;
        s_d.dedS2 = s_q.dedS1;
        s_d.clkS = {s_q.clkS[1:0], pldClk};
        s_d.strbS = {s_q.strbS[1:0], preloadStrobe};
        s_d.enS = {s_q.enS[0], preloadEnable};
        // Output registers: reset, then preload, then clocked set or data
        if (rstT)
        begin
            s_d.regQ = `PMC_REGQ_RST;
        end
        else if (preload)
        begin
            s_d.regQ = s_q.pinS2;
        end
        else if (clkEdge)
        begin
            s_d.regQ = setT ? 10'h3FF : dVal;
        end
        // Pin drive: register value or live sum, gated by its enable term
        s_d.ioOut = (s_q.regQ & regMask) | (dVal & ~regMask);
        s_d.ioOe = oeVal;
        s_d.hresp = 1'b0;
        // Bus slave: one wait state, then answer
        case (s_q.bus)
            pmc_pkg::BUS_IDLE:
            begin
                if (accept)
                begin
                    s_d.bus = pmc_pkg::BUS_DATA;
                    s_d.hreadyout = 1'b0;
                    s_d.wr = hwrite;
                    // Unmapped addresses land on an index nothing decodes
                    s_d.idx = (haddr[31:10] == 22'h00_0000) ? haddr[9:2] : 8'hFF;
                end
            end
            pmc_pkg::BUS_DATA:
            begin
                s_d.bus = pmc_pkg::BUS_IDLE;
                s_d.hreadyout = 1'b1;
                s_d.hrdata = s_q.wr ? 32'h0000_0000 : rdWord;
                if (s_q.wr)
                begin
                    if (s_q.idx < `PMC_CFG_IDX)
                    begin
                        s_d.term[s_q.idx] = hwdata;
                    end
                    else if (s_q.idx == `PMC_CFG_IDX)
                    begin
                        // Configuration pairs sit after the array words
                        s_d.cfg = hwdata[19:0];
                    end
                    else if (s_q.idx == `PMC_CTRL_IDX)
                    begin
                        // Security only sets; a reset clears it
                        s_d.secure = s_q.secure | hwdata[`PMC_SEC_BIT];
                    end
                end
            end
            default:
            begin
                s_d.bus = pmc_pkg::BUS_IDLE;
                s_d.hreadyout = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.bus <= pmc_pkg::BUS_IDLE;
            s_q.hreadyout <= 1'b1;
            s_q.cfg <= `PMC_CFG_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign hreadyout = s_q.hreadyout;
    assign hrdata = s_q.hrdata;
    assign hresp = s_q.hresp;
    assign ioOut = s_q.ioOut;
    assign ioOe = s_q.ioOe;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Bus answer takes exactly one wait state
    sequence waitThenReady;
        !hreadyout ##1 hreadyout;
    endsequence

    bus_wait_a: assert property (accept |=> waitThenReady)
        else $error("bus answer timing wrong");

    preload_capture_a: assert property (preload && !rstT |=> s_q.regQ == $past(s_q.pinS2))
        else $error("preload did not capture pins");

    secure_read_a: assert property (s_q.bus == pmc_pkg::BUS_DATA && !s_q.wr && s_q.secure
        && s_q.idx <= `PMC_CFG_IDX |=> hrdata == 32'h0000_0000)
        else $error("secured map was read back");

    // Security, once on, stays on until the next reset
    secure_stick_a: assert property (s_q.secure |=> s_q.secure)
        else $error("security bit dropped");

    // Status word carries the output registers
    status_read_a: assert property (s_q.bus == pmc_pkg::BUS_DATA && !s_q.wr
        && s_q.idx == `PMC_STAT_IDX |=> hrdata == {22'h00_0000, $past(s_q.regQ)})
        else $error("status read wrong");

    comb_out_a: assert property (1'b1
        |=> ((ioOut ^ $past(dVal)) & ~$past(regMask)) == 10'h000)
        else $error("combinatorial output wrong");

    reg_data_a: assert property (clkEdge && !rstT && !preload && !setT
        |=> s_q.regQ == $past(dVal) ##1 (ioOut & regMask) == (s_q.regQ & regMask) || rstT)
        else $error("registered path wrong");

    oe_term_a: assert property (1'b1 |=> ioOe == $past(oeVal))
        else $error("enable term not on pin");

    cfg_write_a: assert property (s_q.bus == pmc_pkg::BUS_DATA && s_q.wr
        && s_q.idx == `PMC_CFG_IDX |=> s_q.cfg == $past(hwdata[19:0]))
        else $error("configuration write lost");

    sync_set_a: assert property (clkEdge && setT && !rstT && !preload
        |=> s_q.regQ == 10'h3FF)
        else $error("set term failed");

    hold_nclk_a: assert property (!clkEdge && !rstT && !preload |=> $stable(s_q.regQ))
        else $error("registers moved without clock");

    async_clear_a: assert property (rstT |=> s_q.regQ == `PMC_REGQ_RST)
        else $error("reset term failed");

    reset_prio_a: assert property (rstT && setT && clkEdge |=> s_q.regQ == 10'h000)
        else $error("set beat reset");

endmodule : prog_macrocell

// ===== logic/pmc_cfg.svh
// Constants for the programmable output macrocell block
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
// Number of I/O macrocells and dedicated array inputs
`define PMC_CELLS 10
`define PMC_DED 6
// Array signals seen by every product term (dedicated plus feedback)
`define PMC_ARR 16
// Narrowest sum of products; widths step by two toward the middle pins
`define PMC_MIN_SUM 8
`define PMC_WIDE_SUM 16
// Word indices; byte address is four times the index
`define PMC_SET_IDX 8'h82
`define PMC_RST_IDX 8'h83
`define PMC_CFG_IDX 8'h84
`define PMC_CTRL_IDX 8'h85
`define PMC_STAT_IDX 8'h86
`define PMC_TERMS 132
// Control register field
`define PMC_SEC_BIT 0
// Reset values
`define PMC_REGQ_RST 10'h000
`define PMC_CFG_RST 20'h0_0000
`endif

// ===== logic/pmc_pkg.sv
// Types shared by the programmable output macrocell block
package pmc_pkg;
    // Register bus state, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } busState_t;

    // Whole state of the macrocell block
    typedef struct packed {
        logic [131:0][31:0] term;  // Product term cells, one word per term
        logic [19:0] cfg;          // Two cells per macrocell
        logic secure;              // Readback blocked once set
        logic [9:0] regQ;          // Output registers
        logic [9:0] ioOut;         // Pin drive values
        logic [9:0] ioOe;          // Pin drive enables
        logic [9:0] pinS1;         // Pin synchroniser, first stage
        logic [9:0] pinS2;         // Pin synchroniser, second stage
        logic [5:0] dedS1;         // Dedicated input first stage
        logic [5:0] dedS2;         // Dedicated input second stage
        logic [2:0] clkS;          // Device clock pin sync and history
        logic [2:0] strbS;         // Preload strobe sync and history
        logic [1:0] enS;           // Preload enable sync
        busState_t bus;            // Bus slave state
        logic [7:0] idx;           // Word index of the pending access
        logic wr;                  // Pending access is a write
        logic hreadyout;           // Bus ready toward the master
        logic [31:0] hrdata;       // Bus read data
        logic hresp;               // Bus response, always OKAY
    } state_t;
endpackage : pmc_pkg

// ===== verification/pin_tester.sv
// Tester model: drives the pins, the device clock and the preload strobe
`timescale 1ns/1ns

module pin_tester #(
    parameter int STRB_CYC = 12500 // Strobe width in core cycles, 100 us
) (
    input wire logic core_clk, // Core clock
    input wire logic [9:0] ioOut, // Device drive values
    input wire logic [9:0] ioOe, // Device drive enables
    output logic [9:0] ioIn, // Resolved pin levels
    output logic pldClk, // Device clock pin
    output logic preloadStrobe, // Elevated strobe present
    output logic preloadEnable // Preload qualifier pin
);
    logic [9:0] drive = 10'h000; // Tester level on pins the device leaves free
    initial pldClk = 1'b0;
    initial preloadStrobe = 1'b0;
    initial preloadEnable = 1'b0;

    // Device wins on every pin it enables
    assign ioIn = (ioOe & ioOut) | (~ioOe & drive);

    // Tester level on free pins
    task automatic setPins(input logic [9:0] val);
        drive <= val;
        repeat (8) @(posedge core_clk);
    endtask : setPins

    // One slow device clock pulse, then time to settle
    task automatic pulse();
        repeat (4) @(posedge core_clk);
        pldClk <= 1'b1;
        repeat (4) @(posedge core_clk);
        pldClk <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask : pulse

    // Data on pins, qualifier high, long strobe
    task automatic preload(input logic [9:0] val);
        drive <= val;
        preloadEnable <= 1'b1;
        repeat (4) @(posedge core_clk);
        preloadStrobe <= 1'b1;
        repeat (STRB_CYC) @(posedge core_clk);
        preloadStrobe <= 1'b0;
        repeat (4) @(posedge core_clk);
        preloadEnable <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : preload
endmodule : pin_tester

// ===== verification/programmable_output_macrocell_tb_top.sv
// Bench for the macrocell block: bus tasks and pin scenarios
`timescale 1ns/1ns
`include "pmc_cfg.svh"

module programmable_output_macrocell_tb_top;
    logic core_clk, rst, hsel, hwrite, hreadyout, hresp; // Clock, reset, bus
    logic [31:0] haddr, hwdata, hrdata; // Bus words
    logic [1:0] htrans; // Transfer type
    logic [2:0] hsize; // Transfer size
    logic [5:0] dedIn; // Dedicated inputs
    logic [9:0] ioIn, ioOut, ioOe; // Pins
    logic pldClk, preloadStrobe, preloadEnable; // Tester controls
    logic [31:0] rd; // Last read word
    int mismatches = 0; // Failed comparisons
    int comparisons = 0; // All comparisons

    prog_macrocell i_prog_macrocell (.core_clk(core_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .dedIn(dedIn), .pldClk(pldClk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
        .preloadStrobe(preloadStrobe), .preloadEnable(preloadEnable));
    pin_tester i_pin_tester (.core_clk(core_clk), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn),
        .pldClk(pldClk), .preloadStrobe(preloadStrobe), .preloadEnable(preloadEnable));

    // 125 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Report and end the run
    task automatic wrap_up();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // Wait, bounded, for ready sampled high at a rising edge
    task automatic waitRdy();
        int n;
        n = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                mismatches++;
                wrap_up();
            end
            @(posedge core_clk);
        end
    endtask : waitRdy

    // One single word transfer
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waitRdy();
        rd = hrdata;
    endtask : bus

    // Read and compare
    task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        check(rd, exp);
    endtask : rdChk

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        dedIn = 6'h00;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // Virgin state, unmapped place
        rdChk(`PMC_CFG_IDX, 32'h0000_0000);
        check(32'(ioOe), 32'h0000_0000);
        bus(1'b1, 8'hC0, 32'hFFFF_FFFF);
        rdChk(8'hC0, 32'h0000_0000);
        bus(1'b1, 8'h05, 32'h1234_5678);
        rdChk(8'h05, 32'h1234_5678);
        // Cell 0: enable always, sum is dedicated input 0; all four modes
        bus(1'b1, 8'h00, 32'hFFFF_FFFF);
        bus(1'b1, 8'h01, 32'hFFFF_FFFE);
        for (logic [2:0] m = 0; m < 4; m++)
            for (logic [1:0] d = 0; d < 2; d++)
            begin
                bus(1'b1, `PMC_CFG_IDX, 32'(m));
                dedIn <= {5'h00, d[0]};
                i_pin_tester.pulse();
                check(32'({ioOe[0], ioOut[0]}), 32'({1'b1, d[0] ^ ~m[1]}));
            end
        // Cell 0 pin as input feeding cell 1; last sum term of cell 9
        bus(1'b1, 8'h00, 32'h0000_0000);
        bus(1'b1, 8'h09, 32'hFFFF_FFFF);
        bus(1'b1, 8'h0A, 32'hFFFF_EFFF);
        bus(1'b1, 8'h79, 32'hFFFF_FFFF);
        bus(1'b1, 8'h81, 32'hFFFF_FFFF);
        bus(1'b1, `PMC_CFG_IDX, 32'h0008_000A);
        i_pin_tester.setPins(10'h001);
        check(32'({ioOe[0], ioOut[1], ioOut[9]}), 32'h0000_0003);
        i_pin_tester.setPins(10'h000);
        check(32'(ioOut[1]), 32'h0000_0000);
        // Preload with all outputs released
        bus(1'b1, 8'h09, 32'h0000_0000);
        bus(1'b1, 8'h79, 32'h0000_0000);
        i_pin_tester.preload(10'h2A5);
        rdChk(`PMC_STAT_IDX, 32'h0000_02A5);
        // Set waits for the device clock
        bus(1'b1, `PMC_SET_IDX, 32'hFFFF_FFFF);
        dedIn <= 6'h00;
        rdChk(`PMC_STAT_IDX, 32'h0000_02A5);
        bus(1'b1, `PMC_RST_IDX, 32'hFFFF_FFFE);
        i_pin_tester.pulse();
        rdChk(`PMC_STAT_IDX, 32'h0000_03FF);
        // Reset term is dedicated input 0: clears with no clock, beats set
        dedIn <= 6'h01;
        repeat (8) @(posedge core_clk);
        rdChk(`PMC_STAT_IDX, 32'h0000_0000);
        i_pin_tester.pulse();
        rdChk(`PMC_STAT_IDX, 32'h0000_0000);
        // Security blocks map readback only
        rdChk(8'h01, 32'hFFFF_FFFE);
        rdChk(`PMC_CFG_IDX, 32'h0008_000A);
        bus(1'b1, `PMC_CTRL_IDX, 32'h0000_0001);
        rdChk(`PMC_CTRL_IDX, 32'h0000_0001);
        // Writing zero must not clear security
        bus(1'b1, `PMC_CTRL_IDX, 32'h0000_0000);
        rdChk(`PMC_CTRL_IDX, 32'h0000_0001);
        rdChk(8'h01, 32'h0000_0000);
        rdChk(`PMC_CFG_IDX, 32'h0000_0000);
        check(32'(hresp), 32'h0000_0000);
        wrap_up();
    end
endmodule : programmable_output_macrocell_tb_top
